/* servo_homing_defines.svh */
// Named offsets, field positions, reset values and codes for the homing sequencer.
// Assumes inclusion by bare name from the package, the sequencer and the bench.
`ifndef SERVO_HOMING_DEFINES_SVH
`define SERVO_HOMING_DEFINES_SVH

// Register offsets on the parameter port.
`define OFS_ACCEL_TIME     16'h0122
`define OFS_DECEL_TIME     16'h0123
`define OFS_S_CURVE_TIME   16'h0124
`define OFS_HOMING_MODE    16'h012f
`define OFS_FAST_SPEED     16'h0130
`define OFS_SLOW_SPEED     16'h0131
`define OFS_OFFSET_REVS    16'h0132
`define OFS_OFFSET_PULSES  16'h0133
`define OFS_STATUS         16'h0140
`define OFS_INPUT_MAP      16'h0141
`define OFS_OUTPUT_MAP     16'h0142

// Selector digit positions inside the homing mode word.
`define HM_SENSOR_MSB      3
`define HM_SENSOR_LSB      0
`define HM_METHOD_MSB      7
`define HM_METHOD_LSB      4
`define HM_ENABLE_MSB      11
`define HM_ENABLE_LSB      8
`define HM_STOP_MSB        15
`define HM_STOP_LSB        12

// Reset value of every parameter register and the read value of a hole.
`define REG_RESET          16'h0000

// Function codes for the trigger input and the completion output.
`define DI_TRIGGER_NO      16'h007f
`define DI_TRIGGER_NC      16'h001b
`define DO_DONE_A          16'h0009
`define DO_DONE_B          16'h006d

// Encoder pulses in one revolution of offset.
`define PULSES_PER_REV     32'h0000_2710

`endif

/* servo_homing_pkg.sv */
// Types shared by the homing sequencer: selector enums, pin and motion carriers.
// Assumes the defines header sits in the same folder.
`include "servo_homing_defines.svh"
package servo_homing_pkg;

   // Sequencer states, Gray coded along the search, stop and return path.
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_FAST   = 3'h1,
      ST_SLOW   = 3'h3,
      ST_STOP   = 3'h2,
      ST_RETURN = 3'h6
   } home_state_t;

   // Selector values of the four mode digits.
   typedef enum logic [3:0] {
      SNS_FWD_LIMIT = 4'h0, SNS_REV_LIMIT = 4'h1, SNS_REF_FWD = 4'h2,
      SNS_REF_REV   = 4'h3, SNS_INDEX_FWD = 4'h4, SNS_INDEX_REV = 4'h5
   } sensor_sel_t;
   typedef enum logic [3:0] {
      MTH_RETURN = 4'h0, MTH_ONWARD = 4'h1, MTH_DIRECT = 4'h2
   } method_sel_t;
   typedef enum logic [3:0] {
      EN_OFF = 4'h0, EN_AUTO = 4'h1, EN_TRIGGER = 4'h2
   } enable_sel_t;
   typedef enum logic [3:0] {
      STP_CORRECT = 4'h0, STP_KEEP = 4'h1
   } stop_sel_t;

   // Pin inputs from outside the clock domain.
   typedef struct packed {
      logic servo_on;
      logic alarm;
      logic homing_trigger_input;
      logic index_pulse;
      logic reference_sensor_input;
      logic reverse_travel_limit;
      logic forward_travel_limit;
   } pins_t;

   // Command to the motion generator.
   typedef struct packed {
      logic        run;
      logic        reverse;
      logic        position_mode;
      logic [15:0] speed;
      logic [31:0] target;
      logic [15:0] accel;
      logic [15:0] decel;
      logic        shaping_bypass;
   } motion_cmd_t;

endpackage : servo_homing_pkg

/* servo_homing_sequencer.sv */
// Homing sequencer: finds a reference, settles on the mechanical home, reports completion.
// Assumes a motion generator that follows motion and reports motor_stopped and move_done,
// and an encoder position counter on the same clock.
//
// How it works
// - Mode word holds sensor, method, enable and stop digits, each chosen independently.
// - Sensor 0 homes forward on forward limit; afterwards that limit alarms again.
// - Sensor 1 homes reverse on reverse limit; afterwards that limit alarms again.
// - Sensor 2 homes forward, sensor 3 reverse, both on the home sensor.
// - Sensors 4 and 5 search the index pulse forward or reverse, no sensor.
// - Method 0 reverses at slow speed to the nearest index pulse.
// - Method 1 keeps going at slow speed to the nearest index pulse.
// - Method 2 takes home-sensor rising edge or index as home, then decelerates; with a limit sensor it runs as method 0.
// - Enable 0 disables homing whatever the other digits hold.
// - Enable 1 homes once after power-up when servo-on is present.
// - Enable 2 homes on trigger input, mapped as code 127 or 27.
// - Stop 0 stops, then moves back to the captured home position.
// - Stop 1 stops past home and keeps the captured position unchanged.
// - Completion output mapped as code 09 or 109 goes active at once.
// - Servo-off or alarm during homing aborts without completion.
// - Reference search runs at fast speed, final search at slow speed.
// - Limit references are best used with method 0.
// - Total offset is revolutions times 10000 plus pulses.
// - S-curve value zero bypasses shaping and drops accel and decel times.
//
// Local design decision: the plain strobed port.
`include "servo_homing_defines.svh"
module servo_homing_sequencer #(
   parameter int POS_W = 32
) (
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic                         ce,
   input  wire logic [15:0]                  reg_addr,
   input  wire logic [15:0]                  reg_wdata,
   input  wire logic                         reg_we,
   input  wire logic                         reg_re,
   output      logic [15:0]                  reg_rdata,
   input  wire servo_homing_pkg::pins_t      pins,
   input  wire logic [POS_W-1:0]             enc_pos,
   input  wire logic                         motor_stopped,
   input  wire logic                         move_done,
   output      servo_homing_pkg::motion_cmd_t motion,
   output      logic                         homing_busy,
   output      logic                         home_complete_out,
   output      logic                         limit_alarm,
   output      logic [POS_W-1:0]             home_position,
   output      logic [31:0]                  home_offset
);

   // Register indices of the parameter file.
   localparam int NREG = 10;
   localparam logic [3:0] R_ACCEL = 4'h0;
   localparam logic [3:0] R_DECEL = 4'h1;
   localparam logic [3:0] R_SCURVE = 4'h2;
   localparam logic [3:0] R_MODE = 4'h3;
   localparam logic [3:0] R_FAST = 4'h4;
   localparam logic [3:0] R_SLOW = 4'h5;
   localparam logic [3:0] R_REVS = 4'h6;
   localparam logic [3:0] R_PULSES = 4'h7;
   localparam logic [3:0] R_IMAP = 4'h8;
   localparam logic [3:0] R_OMAP = 4'h9;
   localparam logic [3:0] R_STATUS = 4'ha;
   localparam logic [3:0] R_NONE = 4'hf;
   localparam int NPIN = $bits(servo_homing_pkg::pins_t);

   logic                          rst_meta_q;
   logic                          rst_q;
   logic [15:0]                   regs_q [NREG];
   logic [15:0]                   reg_rdata_q;
   logic [NPIN-1:0]               s1_q;
   logic [NPIN-1:0]               s2_q;
   logic [NPIN-1:0]               s3_q;
   logic [NPIN-1:0]               filt_q;
   servo_homing_pkg::pins_t       pin_f;
   logic                          index_prev_q;
   logic                          ref_prev_q;
   logic                          trig_prev_q;
   logic                          index_rise;
   logic                          ref_rise;
   logic                          trig_rise;
   servo_homing_pkg::home_state_t st_q;
   servo_homing_pkg::home_state_t st_d;
   logic                          done_q;
   logic                          aborted_q;
   logic                          auto_armed_q;
   logic                          slow_rev_q;
   logic [POS_W-1:0]              home_pos_q;
   servo_homing_pkg::motion_cmd_t motion_q;
   logic                          limit_alarm_q;
   logic [31:0]                   home_offset_q;
   logic [3:0]                    sel_a;
   logic [3:0]                    sel_b;
   logic [3:0]                    sel_c;
   logic [3:0]                    sel_d;
   logic                          home_rev;
   logic                          mode_ok;
   logic                          start;
   logic                          abort;
   logic                          ref_found;
   logic                          shaping_off;

   // Maps a bus address onto a register index, or none for a hole.
   function automatic logic [3:0] reg_sel(input logic [15:0] a);
      case (a)
         `OFS_ACCEL_TIME:    reg_sel = R_ACCEL;
         `OFS_DECEL_TIME:    reg_sel = R_DECEL;
         `OFS_S_CURVE_TIME:  reg_sel = R_SCURVE;
         `OFS_HOMING_MODE:   reg_sel = R_MODE;
         `OFS_FAST_SPEED:    reg_sel = R_FAST;
         `OFS_SLOW_SPEED:    reg_sel = R_SLOW;
         `OFS_OFFSET_REVS:   reg_sel = R_REVS;
         `OFS_OFFSET_PULSES: reg_sel = R_PULSES;
         `OFS_INPUT_MAP:     reg_sel = R_IMAP;
         `OFS_OUTPUT_MAP:    reg_sel = R_OMAP;
         `OFS_STATUS:        reg_sel = R_STATUS;
         default:            reg_sel = R_NONE;
      endcase
   endfunction : reg_sel

   // Releases the asynchronous reset through two flip-flops.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_q      <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_q      <= rst_meta_q;
      end
   end

   // Parameter registers; the status word is read only.
   always_ff @(posedge clk or negedge rst_q)
   begin
      if (!rst_q)
      begin
         for (int i = 0; i < NREG; i++)
            regs_q[i] <= `REG_RESET;
      end
      else if (ce && reg_we && reg_sel(reg_addr) < R_STATUS)
      begin
         regs_q[reg_sel(reg_addr)] <= reg_wdata;
      end
   end

   // Read data stands in the cycle after the read strobe and only there.
   always_ff @(posedge clk or negedge rst_q)
   begin
      if (!rst_q)
         reg_rdata_q <= `REG_RESET;
      else if (ce)
      begin
         if (!reg_re || reg_sel(reg_addr) == R_NONE)
            reg_rdata_q <= `REG_RESET;
         else if (reg_sel(reg_addr) == R_STATUS)
            reg_rdata_q <= {10'h000, st_q, aborted_q, done_q, homing_busy};
         else
            reg_rdata_q <= regs_q[reg_sel(reg_addr)];
      end
   end
   assign reg_rdata = reg_rdata_q;

   // Each pin passes three flip-flops and changes once the last two agree.
   genvar g;
   generate
      for (g = 0; g < NPIN; g++)
      begin : g_sync
         always_ff @(posedge clk or negedge rst_q)
         begin
            if (!rst_q)
            begin
               s1_q[g]   <= 1'b0;
               s2_q[g]   <= 1'b0;
               s3_q[g]   <= 1'b0;
               filt_q[g] <= 1'b0;
            end
            else if (ce)
            begin
               s1_q[g] <= pins[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g])
                  filt_q[g] <= s3_q[g];
            end
         end
      end
   endgenerate
   assign pin_f = servo_homing_pkg::pins_t'(filt_q);

   // Mode digits and trigger polarity from the mapping code.
   assign sel_a      = regs_q[R_MODE][`HM_SENSOR_MSB:`HM_SENSOR_LSB];
   assign sel_b      = regs_q[R_MODE][`HM_METHOD_MSB:`HM_METHOD_LSB];
   assign sel_c      = regs_q[R_MODE][`HM_ENABLE_MSB:`HM_ENABLE_LSB];
   assign sel_d      = regs_q[R_MODE][`HM_STOP_MSB:`HM_STOP_LSB];
   assign home_rev   = sel_a[0];
   assign mode_ok    = sel_a <= servo_homing_pkg::SNS_INDEX_REV
                       && sel_b <= servo_homing_pkg::MTH_DIRECT
                       && sel_d <= servo_homing_pkg::STP_KEEP;
   assign index_rise = pin_f.index_pulse && !index_prev_q;
   assign ref_rise   = pin_f.reference_sensor_input && !ref_prev_q;
   // The trigger edge is taken on the pin itself, so a change of mapping is never an edge.
   assign trig_rise  = (regs_q[R_IMAP] == `DI_TRIGGER_NO
                        && pin_f.homing_trigger_input && !trig_prev_q)
                       || (regs_q[R_IMAP] == `DI_TRIGGER_NC
                           && !pin_f.homing_trigger_input && trig_prev_q);

   // Edge history of the filtered inputs.
   always_ff @(posedge clk or negedge rst_q)
   begin
      if (!rst_q)
      begin
         index_prev_q <= 1'b0;
         ref_prev_q   <= 1'b0;
         trig_prev_q  <= 1'b0;
      end
      else if (ce)
      begin
         index_prev_q <= pin_f.index_pulse;
         ref_prev_q   <= pin_f.reference_sensor_input;
         trig_prev_q  <= pin_f.homing_trigger_input;
      end
   end

   // Start, abort and reference detection.
   assign abort = !pin_f.servo_on || pin_f.alarm || limit_alarm_q;
   assign start = st_q == servo_homing_pkg::ST_IDLE && mode_ok && !abort
                  && ((sel_c == servo_homing_pkg::EN_AUTO && auto_armed_q)
                      || (sel_c == servo_homing_pkg::EN_TRIGGER && trig_rise));
   always_comb
   begin
      case (sel_a)
         servo_homing_pkg::SNS_FWD_LIMIT: ref_found = pin_f.forward_travel_limit;
         servo_homing_pkg::SNS_REV_LIMIT: ref_found = pin_f.reverse_travel_limit;
         servo_homing_pkg::SNS_REF_FWD,
         servo_homing_pkg::SNS_REF_REV:   ref_found = ref_rise;
         default:                         ref_found = index_rise;
      endcase
   end

   // Next state of the sequence.
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         servo_homing_pkg::ST_IDLE:
            if (start)
               st_d = servo_homing_pkg::ST_FAST;
         servo_homing_pkg::ST_FAST:
            if (ref_found)
               st_d = (sel_b == servo_homing_pkg::MTH_DIRECT
                       && sel_a >= servo_homing_pkg::SNS_REF_FWD)
                      ? servo_homing_pkg::ST_STOP : servo_homing_pkg::ST_SLOW;
         servo_homing_pkg::ST_SLOW:
            if (index_rise)
               st_d = servo_homing_pkg::ST_STOP;
         servo_homing_pkg::ST_STOP:
            if (motor_stopped)
               st_d = (sel_d == servo_homing_pkg::STP_CORRECT)
                      ? servo_homing_pkg::ST_RETURN : servo_homing_pkg::ST_IDLE;
         servo_homing_pkg::ST_RETURN:
            if (move_done)
               st_d = servo_homing_pkg::ST_IDLE;
         default:
            st_d = servo_homing_pkg::ST_IDLE;
      endcase
      if (abort)
         st_d = servo_homing_pkg::ST_IDLE;
   end

   // State register; a trigger while running has no effect on it.
   always_ff @(posedge clk or negedge rst_q)
   begin
      if (!rst_q)
         st_q <= servo_homing_pkg::ST_IDLE;
      else if (ce)
         st_q <= st_d;
   end

   // Completion and abort flags, the one-shot power-up arm and captured home.
   always_ff @(posedge clk or negedge rst_q)
   begin
      if (!rst_q)
      begin
         done_q       <= 1'b0;
         aborted_q    <= 1'b0;
         auto_armed_q <= 1'b1;
         slow_rev_q   <= 1'b0;
         home_pos_q   <= '0;
      end
      else if (ce)
      begin
         if (start)
         begin
            done_q       <= 1'b0;
            aborted_q    <= 1'b0;
            auto_armed_q <= 1'b0;
            slow_rev_q   <= (sel_b == servo_homing_pkg::MTH_ONWARD) ? home_rev : !home_rev;
         end
         if (st_q != servo_homing_pkg::ST_IDLE && abort)
            aborted_q <= 1'b1;
         else if (st_q != servo_homing_pkg::ST_IDLE && st_d == servo_homing_pkg::ST_IDLE)
            done_q <= 1'b1;
         if (st_d == servo_homing_pkg::ST_STOP && st_q != servo_homing_pkg::ST_STOP)
            home_pos_q <= enc_pos;
      end
   end

   // Motion command follows the next state so it stands beside the state register.
   assign shaping_off = regs_q[R_SCURVE] == `REG_RESET;
   always_ff @(posedge clk or negedge rst_q)
   begin
      if (!rst_q)
         motion_q <= '0;
      else if (ce)
      begin
         motion_q.run            <= st_d == servo_homing_pkg::ST_FAST
                                    || st_d == servo_homing_pkg::ST_SLOW
                                    || st_d == servo_homing_pkg::ST_RETURN;
         motion_q.reverse        <= (st_d == servo_homing_pkg::ST_SLOW) ? slow_rev_q : home_rev;
         motion_q.position_mode  <= st_d == servo_homing_pkg::ST_RETURN;
         motion_q.speed          <= (st_d == servo_homing_pkg::ST_FAST) ? regs_q[R_FAST]
                                    : (st_d == servo_homing_pkg::ST_IDLE) ? `REG_RESET
                                    : regs_q[R_SLOW];
         motion_q.target         <= 32'(home_pos_q);
         motion_q.accel          <= shaping_off ? `REG_RESET : regs_q[R_ACCEL];
         motion_q.decel          <= shaping_off ? `REG_RESET : regs_q[R_DECEL];
         motion_q.shaping_bypass <= shaping_off;
      end
   end

   // Limits return to limit duty except the one serving as reference in a search.
   always_ff @(posedge clk or negedge rst_q)
   begin
      if (!rst_q)
         limit_alarm_q <= 1'b0;
      else if (ce)
         limit_alarm_q <= (pin_f.forward_travel_limit && !(st_q != servo_homing_pkg::ST_IDLE
                           && sel_a == servo_homing_pkg::SNS_FWD_LIMIT))
                          || (pin_f.reverse_travel_limit && !(st_q != servo_homing_pkg::ST_IDLE
                           && sel_a == servo_homing_pkg::SNS_REV_LIMIT));
   end

   // Total homing offset in encoder pulses.
   always_ff @(posedge clk or negedge rst_q)
   begin
      if (!rst_q)
         home_offset_q <= '0;
      else if (ce)
         home_offset_q <= 32'(regs_q[R_REVS]) * `PULSES_PER_REV + 32'(regs_q[R_PULSES]);
   end

   // Outputs.
   assign motion            = motion_q;
   assign homing_busy       = st_q != servo_homing_pkg::ST_IDLE;
   assign home_complete_out = done_q && (regs_q[R_OMAP] == `DO_DONE_A
                                         || regs_q[R_OMAP] == `DO_DONE_B);
   assign limit_alarm       = limit_alarm_q;
   assign home_position     = home_pos_q;
   assign home_offset       = home_offset_q;

   // Disabled homing never leaves idle.
   property p_disabled;
      @(posedge clk) disable iff (!rst_q)
      (st_q == servo_homing_pkg::ST_IDLE && sel_c == servo_homing_pkg::EN_OFF)
      |=> st_q == servo_homing_pkg::ST_IDLE;
   endproperty
   a_disabled: assert property (p_disabled) else $error("homing left idle while disabled");

   // Servo-off or alarm aborts without completion.
   property p_abort;
      @(posedge clk) disable iff (!rst_q)
      (ce && st_q != servo_homing_pkg::ST_IDLE && abort)
      |=> st_q == servo_homing_pkg::ST_IDLE && !done_q && !home_complete_out;
   endproperty
   a_abort: assert property (p_abort) else $error("abort did not end homing cleanly");

   // Reference search runs at the fast speed in the homing direction.
   property p_fast;
      @(posedge clk) disable iff (!rst_q)
      st_q == servo_homing_pkg::ST_FAST
      |-> motion.run && motion.speed == regs_q[R_FAST] && motion.reverse == home_rev;
   endproperty
   a_fast: assert property (p_fast) else $error("fast search command wrong");

   // Method 0 turns back at the slow speed.
   property p_method_return;
      @(posedge clk) disable iff (!rst_q)
      (st_q == servo_homing_pkg::ST_SLOW && sel_b == servo_homing_pkg::MTH_RETURN)
      |-> motion.reverse != home_rev && motion.speed == regs_q[R_SLOW];
   endproperty
   a_method_return: assert property (p_method_return) else $error("method 0 direction wrong");

   // Stop setting 1 finishes as soon as the motor stands.
   property p_stop_keep;
      @(posedge clk) disable iff (!rst_q)
      (ce && st_q == servo_homing_pkg::ST_STOP && sel_d == servo_homing_pkg::STP_KEEP
       && motor_stopped && !abort)
      |=> st_q == servo_homing_pkg::ST_IDLE && done_q && home_position == $past(home_pos_q);
   endproperty
   a_stop_keep: assert property (p_stop_keep) else $error("stop setting 1 did not finish");

   // Stop setting 0 moves back to the captured home.
   property p_stop_correct;
      @(posedge clk) disable iff (!rst_q)
      (ce && st_q == servo_homing_pkg::ST_STOP && sel_d == servo_homing_pkg::STP_CORRECT
       && motor_stopped && !abort)
      |=> motion.position_mode && motion.target == 32'(home_pos_q);
   endproperty
   a_stop_correct: assert property (p_stop_correct) else $error("no return to home");

   // Completion output follows completion when mapped as code 109.
   property p_done_out;
      @(posedge clk) disable iff (!rst_q)
      (done_q && regs_q[R_OMAP] == `DO_DONE_B) |-> home_complete_out;
   endproperty
   a_done_out: assert property (p_done_out) else $error("completion output missing");

   // Offset equals revolutions times pulses per revolution plus pulses.
   property p_offset;
      @(posedge clk) disable iff (!rst_q)
      ce |=> home_offset == 32'($past(regs_q[R_REVS])) * `PULSES_PER_REV
                           + 32'($past(regs_q[R_PULSES]));
   endproperty
   a_offset: assert property (p_offset) else $error("homing offset wrong");

   // Zero S-curve removes acceleration and deceleration times.
   property p_bypass;
      @(posedge clk) disable iff (!rst_q)
      (ce && shaping_off) |=> motion.accel == 16'h0000 && motion.decel == 16'h0000;
   endproperty
   a_bypass: assert property (p_bypass) else $error("shaping not bypassed");

   // A trigger during a slow search does not restart the sequence.
   property p_no_restart;
      @(posedge clk) disable iff (!rst_q)
      (st_q == servo_homing_pkg::ST_SLOW && trig_rise) |=> st_q != servo_homing_pkg::ST_FAST;
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("trigger restarted homing");

endmodule : servo_homing_sequencer

/* motor_model.sv */
// Motor, encoder and drive stage model facing the homing sequencer.
// Assumes the sequencer's motion command arrives on the same clock.
module motor_model (
   input  wire logic                          clk,
   input  wire servo_homing_pkg::motion_cmd_t motion,
   output      logic                          motor_stopped,
   output      logic                          move_done,
   output      logic [31:0]                   enc_pos
);
   timeunit 1ns;
   timeprecision 1ps;
   initial enc_pos = 32'h0000_0000;
   // Encoder counts while running; standstill and arrival show one cycle late.
   always @(posedge clk)
   begin
      enc_pos <= enc_pos + {31'h0, motion.run};
      motor_stopped <= !motion.run;
      move_done <= motion.run & motion.position_mode;
   end
endmodule : motor_model

/* servo_homing_sequencer_tb.sv */
// Self-checking bench for the homing sequencer: register access and homing runs.
// Assumes the motor model drives the motor feedback; the bench drives pins and registers.
`include "servo_homing_defines.svh"
module servo_homing_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, ce = 1, we = 0, re = 0, stp, mdone, busy, cmpl, lal;
   logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
   logic [31:0] pos, hpos, hoff;
   servo_homing_pkg::pins_t pins = '0;
   servo_homing_pkg::motion_cmd_t motion;
   int n_errors = 0, checks_done = 0, cyc = 0;
   servo_homing_sequencer dut (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(addr),
      .reg_wdata(wdata), .reg_we(we), .reg_re(re), .reg_rdata(rdata), .pins(pins),
      .enc_pos(pos), .motor_stopped(stp), .move_done(mdone), .motion(motion),
      .homing_busy(busy), .home_complete_out(cmpl), .limit_alarm(lal),
      .home_position(hpos), .home_offset(hoff));
   motor_model partner (.clk(clk), .motion(motion), .motor_stopped(stp),
      .move_done(mdone), .enc_pos(pos));
   initial forever #5 clk = ~clk;
   // Cuts a hang short.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         n_errors++;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 chk({16'h0, rdata}, {16'h0, exp});
   endtask : rd
   // Waits for a pin level to pass the synchronisers.
   task automatic settle();
      repeat (6) @(posedge clk);
      #1;
   endtask : settle
   task automatic trig();
      @(posedge clk) pins.homing_trigger_input <= 1'b1;
      settle();
      @(posedge clk) pins.homing_trigger_input <= 1'b0;
      settle();
   endtask : trig
   task automatic results();
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      pins.servo_on <= 1'b1;
      repeat (4) @(posedge clk);
      rd(`OFS_HOMING_MODE, `REG_RESET);
      rd(16'h0125, 16'h0000);
      wr(`OFS_OFFSET_REVS, 16'h0003);
      wr(`OFS_OFFSET_PULSES, 16'h0005);
      wr(`OFS_FAST_SPEED, 16'h0040);
      wr(`OFS_SLOW_SPEED, 16'h0008);
      wr(`OFS_INPUT_MAP, `DI_TRIGGER_NO);
      wr(`OFS_OUTPUT_MAP, `DO_DONE_A);
      wr(`OFS_HOMING_MODE, 16'h0002);
      trig();
      chk(busy, 1'b0);
      wr(`OFS_HOMING_MODE, 16'h0202);
      ce <= 1'b0;
      wr(`OFS_SLOW_SPEED, 16'h0077);
      ce <= 1'b1;
      rd(`OFS_SLOW_SPEED, 16'h0008);
      rd(`OFS_HOMING_MODE, 16'h0202);
      chk(hoff, 32'h0000_7535);
      trig();
      chk({busy, motion.run, motion.reverse, motion.speed}, {3'b110, 16'h0040});
      chk(motion.shaping_bypass, 1'b1);
      @(posedge clk) pins.reference_sensor_input <= 1'b1;
      settle();
      chk({motion.reverse, motion.speed}, {1'b1, 16'h0008});
      trig();
      chk({busy, motion.speed}, {1'b1, 16'h0008});
      @(posedge clk) pins.index_pulse <= 1'b1;
      wait (cmpl === 1'b1);
      #1 chk({busy, cmpl}, 2'b01);
      @(posedge clk) pins.reference_sensor_input <= 1'b0;
      pins.index_pulse <= 1'b0;
      settle();
      trig();
      @(posedge clk) pins.servo_on <= 1'b0;
      settle();
      chk({busy, cmpl}, 2'b00);
      rd(`OFS_STATUS, 16'h0004);
      // Second power-up: auto homing on the index pulse, stop without correction.
      @(posedge clk) rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      wr(`OFS_FAST_SPEED, 16'h0040);
      wr(`OFS_OUTPUT_MAP, `DO_DONE_B);
      wr(`OFS_HOMING_MODE, 16'h1124);
      pins.servo_on <= 1'b1;
      settle();
      chk({busy, motion.run, motion.reverse, motion.speed}, {3'b110, 16'h0040});
      @(posedge clk) pins.index_pulse <= 1'b1;
      wait (cmpl === 1'b1);
      #1 chk({busy, motion.run, motion.position_mode}, 3'b000);
      chk(hpos + 32'h0000_0001, pos);
      settle();
      chk({busy, cmpl}, 2'b01);
      rd(`OFS_STATUS, 16'h0002);
      @(posedge clk) pins.forward_travel_limit <= 1'b1;
      settle();
      chk(lal, 1'b1);
      results();
   end
endmodule : servo_homing_sequencer_tb
